// ### hw/comparator_control.sv
`timescale 1ns/10ps
`default_nettype none
module comparator_control
   import comparator_pkg::*;
#(
   parameter int STARTUP_REF_COUNT = STARTUP_REF_CYCLES
) (
   input  wire logic       clk_sys,           // peripheral clock, 40 MHz
   input  wire logic       sys_rst,           // synchronous reset, high
   input  wire logic [2:0] reg_addr,          // register offset
   input  wire logic [7:0] reg_wdata,         // write data
   input  wire logic       reg_write,         // write strobe
   input  wire logic       reg_read,          // read strobe
   output logic      [7:0] reg_rdata,         // read data, cycle after strobe
   input  wire logic [1:0] sleep_mode,        // 0 active,1 idle,2 standby,3 power down
   input  wire logic       clk_requested,     // another module keeps clock in standby
   input  wire logic       core_out,          // raw analog comparator output
   output logic            core_enable,       // analog core on
   output logic      [1:0] hysteresis_level,  // hysteresis selection
   output logic            low_power_bias,    // reduced current
   output logic      [1:0] positive_input_select, // positive mux
   output logic      [1:0] negative_input_select, // negative mux
   output logic            event_out,         // unsynchronised event source
   output logic            pad_out,           // pad data
   output logic            pad_oe_n,          // pad enable, low drives
   output logic            output_valid,      // startup time elapsed
   output logic            irq                // interrupt request
);
   logic [7:0]  control_reg;
   logic [7:0]  input_sel_reg;
   logic        irq_enable_reg;
   logic        flag_reg;
   logic [2:0]  sync_reg;
   logic [7:0]  rdata_reg;
   logic [15:0] startup_reg;
   logic [15:0] startup_next;
   logic        flag_next;

   wire         in_standby   = (sleep_mode == SLEEP_STANDBY);
   wire         in_power_dn  = (sleep_mode == SLEEP_POWER_DN);
   // standby halts unless kept running; power down always halts
   wire         halted       = in_power_dn || (in_standby && !control_reg[BIT_KEEP_RUN]);
   wire         running      = control_reg[BIT_ENABLE] && !halted;
   // without clock requests the status side freezes in standby
   wire         status_live  = !(in_standby && !clk_requested);
   wire         inverted_out = core_out ^ input_sel_reg[BIT_INVERT];
   wire         sel_edge_any = (control_reg[BIT_EDGE_LO+:2] == EDGE_ANY);
   wire         sel_edge_f   = (control_reg[BIT_EDGE_LO+:2] == EDGE_FALL);
   wire         sel_edge_r   = (control_reg[BIT_EDGE_LO+:2] == EDGE_RISE);
   // raw pin passes two flops before the invert; the history stage keeps the inverted level
   wire         sync_level   = sync_reg[1] ^ input_sel_reg[BIT_INVERT];
   wire         rise         = sync_level && !sync_reg[2];
   wire         fall         = !sync_level && sync_reg[2];
   // reserved edge code 1 sets nothing
   wire         edge_hit     = running && status_live && output_valid &&
                               ((sel_edge_any && (rise || fall)) || (sel_edge_f && fall) || (sel_edge_r && rise));
   wire         wr_control   = reg_write && (reg_addr == ADDR_CONTROL);
   wire         wr_input     = reg_write && (reg_addr == ADDR_INPUT_SEL);
   wire         wr_irq_en    = reg_write && (reg_addr == ADDR_IRQ_ENABLE);
   wire         wr_status    = reg_write && (reg_addr == ADDR_IRQ_STATUS);
   wire         clear_flag   = wr_status && reg_wdata[BIT_FLAG];
   wire [15:0]  startup_len  = (input_sel_reg[BIT_NEG_LO+:2] == NEG_REFERENCE) ?
                               16'(STARTUP_REF_COUNT) : 16'(STARTUP_CORE_CYCLES);

   assign core_enable           = running;
   assign hysteresis_level      = control_reg[BIT_HYST_LO+:2];
   assign low_power_bias        = control_reg[BIT_LOW_POWER];
   assign positive_input_select = input_sel_reg[BIT_POS_LO+:2];
   assign negative_input_select = input_sel_reg[BIT_NEG_LO+:2];
   assign event_out             = running && inverted_out;
   assign pad_out               = running && inverted_out;
   assign pad_oe_n              = !(control_reg[BIT_PAD_ENABLE] && !in_power_dn);
   assign irq                   = irq_enable_reg && flag_reg;
   assign reg_rdata             = rdata_reg;
   assign output_valid          = running && (startup_reg == 16'h0000);
   // set wins over a clear in the same cycle
   assign flag_next             = edge_hit ? 1'b1 : (clear_flag ? 1'b0 : flag_reg);
   assign startup_next          = !running ? startup_len :
                                  (startup_reg != 16'h0000) ? startup_reg - 16'h0001 : startup_reg;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         control_reg    <= RESET_VALUE;
         input_sel_reg  <= RESET_VALUE;
         irq_enable_reg <= 1'b0;
         flag_reg       <= 1'b0;
         sync_reg       <= 3'h0;
         rdata_reg      <= 8'h00;
         // loaded with the core length so an enable right after reset still waits
         startup_reg    <= 16'(STARTUP_CORE_CYCLES);
      end else begin
         if (wr_control) begin
            control_reg <= reg_wdata & MASK_CONTROL;
         end
         if (wr_input) begin
            input_sel_reg <= reg_wdata & MASK_INPUT_SEL;
         end
         if (wr_irq_en) begin
            irq_enable_reg <= reg_wdata[0];
         end
         flag_reg    <= flag_next;
         startup_reg <= startup_next;
         // two-stage synchroniser then a history stage; frozen in standby when clock is unrequested
         if (status_live) begin
            sync_reg <= {sync_level, sync_reg[0], core_out};
         end
         if (reg_read) begin
            case (reg_addr)
               ADDR_CONTROL:    rdata_reg <= control_reg;
               ADDR_INPUT_SEL:  rdata_reg <= input_sel_reg;
               ADDR_IRQ_ENABLE: rdata_reg <= {7'h00, irq_enable_reg};
               ADDR_IRQ_STATUS: rdata_reg <= {3'h0, sync_reg[2], 3'h0, flag_reg};
               default:         rdata_reg <= 8'h00;
            endcase
         end else begin
            rdata_reg <= 8'h00;
         end
      end
   end

   a_irq_follows_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (irq == (irq_enable_reg && flag_reg))) else $error("irq not flag and enable");
   a_clear_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clear_flag && !edge_hit) |=> !flag_reg) else $error("flag not cleared");
   a_edge_sets: assert property (@(posedge clk_sys) disable iff (sys_rst)
      edge_hit |=> flag_reg) else $error("edge did not set flag");
   a_zero_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (flag_reg && wr_status && !reg_wdata[0]) |=> flag_reg) else $error("zero write cleared flag");
   a_power_down_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
      in_power_dn |-> (!core_enable && pad_oe_n)) else $error("power down left core on");
   a_state_three: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (status_live[*3]) |=> (sync_reg[2] == ($past(core_out, 3) ^ $past(input_sel_reg[BIT_INVERT]))))
      else $error("state delay wrong");
   a_no_edge_reserved: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (control_reg[5:4] == 2'h1) |-> !edge_hit) else $error("reserved mode set flag");
   a_startup_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(running) |-> !output_valid[*8]) else $error("output valid too early");
   a_event_gated: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !running |-> (!event_out && !pad_out)) else $error("event or pad active while stopped");
   a_pad_enable: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (control_reg[BIT_PAD_ENABLE] && !in_power_dn) |-> !pad_oe_n) else $error("pad not driven");
   a_status_frozen: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !status_live |=> $stable(sync_reg)) else $error("status moved without clock");
   a_idle_runs: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (sleep_mode == SLEEP_IDLE) |-> (core_enable == control_reg[BIT_ENABLE])) else $error("idle stopped core");
   a_flag_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!edge_hit && !clear_flag) |=> $stable(flag_reg)) else $error("flag changed without cause");
endmodule // comparator_control
`default_nettype wire

// ### hw/comparator_pkg.sv
// Function
// - output invalid 2.5 us, 60 us with reference
// - control bits 2:1 choose hysteresis level
// - one positive, one negative input select field
// - low power bit reduces bias current
// - unsynchronised output, after the invert bit, offered as event while enabled
// - control bits 5:4 choose flag edge
// - single interrupt source, comparator toggle
// - selected edge sets status bit 0
// - request while enable and flag both set
// - idle sleep runs as active
// - standby halts unless keep running set
// - power down disables comparator and pad
// - control bit 6 drives pad
// - control bit 0 enables, fields reset zero
// - negative field: pin0, pin1, reference, converter
// - invert bit 7 applies to every consumer
// - state bit 4 after three cycles
// - writing one clears flag, zero keeps
package comparator_pkg;
   localparam logic [2:0] ADDR_CONTROL    = 3'h0;
   localparam logic [2:0] ADDR_INPUT_SEL  = 3'h2;
   localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h6;
   localparam logic [2:0] ADDR_IRQ_STATUS = 3'h7;
   localparam logic [7:0] RESET_VALUE     = 8'h00;
   localparam int BIT_ENABLE     = 0;
   localparam int BIT_HYST_LO    = 1;
   localparam int BIT_LOW_POWER  = 3;
   localparam int BIT_EDGE_LO    = 4;
   localparam int BIT_PAD_ENABLE = 6;
   localparam int BIT_KEEP_RUN   = 7;
   localparam int BIT_NEG_LO     = 0;
   localparam int BIT_POS_LO     = 3;
   localparam int BIT_INVERT     = 7;
   localparam int BIT_FLAG       = 0;
   localparam int BIT_STATE      = 4;
   localparam logic [7:0] MASK_CONTROL   = 8'hFF;
   localparam logic [7:0] MASK_INPUT_SEL = 8'h9B;
   localparam logic [1:0] EDGE_ANY       = 2'h0;
   localparam logic [1:0] EDGE_FALL      = 2'h2;
   localparam logic [1:0] EDGE_RISE      = 2'h3;
   localparam logic [1:0] SLEEP_ACTIVE   = 2'h0;
   localparam logic [1:0] SLEEP_IDLE     = 2'h1;
   localparam logic [1:0] SLEEP_STANDBY  = 2'h2;
   localparam logic [1:0] SLEEP_POWER_DN = 2'h3;
   localparam int CLOCK_MHZ          = 40;
   localparam int STARTUP_CORE_NS    = 2500;
   localparam int STARTUP_REF_NS     = 60000;
   localparam int STARTUP_CORE_CYCLES = (STARTUP_CORE_NS * CLOCK_MHZ + 999) / 1000;
   localparam int STARTUP_REF_CYCLES  = (STARTUP_REF_NS * CLOCK_MHZ + 999) / 1000;
   localparam logic [1:0] NEG_REFERENCE = 2'h2;
endpackage

// ### test/comparator_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module comparator_core_model (
   input  wire logic clk_sys,     // peripheral clock
   input  wire logic core_enable, // analog core powered
   input  wire logic level,       // comparison result to show
   output logic      core_out     // raw comparator output
);
   // an unpowered core rests low, so status reads stay predictable while stopped
   assign core_out = core_enable && level;
endmodule // comparator_core_model
`default_nettype wire

// ### test/tb_comparator_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_comparator_control;
   import comparator_pkg::*;
   logic       clk_sys = 0, sys_rst = 1, reg_write = 0, reg_read = 0, clk_requested = 0, level = 0, rd_seen = 0;
   logic [2:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, reg_rdata, v;
   logic [1:0] sleep_mode = 0, hysteresis_level, positive_input_select, negative_input_select;
   logic       core_enable, low_power_bias, event_out, pad_out, pad_oe_n, output_valid, irq, core_out;
   logic [7:0] exp_q[$];
   logic [1:0] modes[3] = '{EDGE_ANY, EDGE_FALL, EDGE_RISE};
   int         failures = 0, samples_checked = 0, seed = 74990;
   always #12.5 clk_sys = ~clk_sys;
   comparator_control #(.STARTUP_REF_COUNT(20)) DUT (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .sleep_mode, .clk_requested, .core_out, .core_enable, .hysteresis_level,
      .low_power_bias, .positive_input_select, .negative_input_select, .event_out, .pad_out, .pad_oe_n,
      .output_valid, .irq);
   comparator_core_model CORE (.clk_sys, .core_enable, .level, .core_out);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_write <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_read <= 1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 0;
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // read data stands only in the cycle after the strobe, so sample it mid-cycle there
   always @(posedge clk_sys) rd_seen <= reg_read;
   always @(negedge clk_sys) begin
      if (rd_seen) check(reg_rdata, exp_q.pop_front());
   end
   initial begin
      #100000;
      failures++;
      report_and_stop;
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 0;
      for (int a = 0; a < 8; a++) rd(a[2:0], RESET_VALUE);
      $display("reset values test done");
      v = $random(seed);
      wr(ADDR_CONTROL, v & 8'hFE);
      rd(ADDR_CONTROL, v & 8'hFE);
      @(negedge clk_sys);
      check({6'h0, hysteresis_level}, {6'h0, v[2:1]});
      check({7'h0, low_power_bias}, {7'h0, v[3]});
      v = $random(seed);
      wr(ADDR_INPUT_SEL, v);
      rd(ADDR_INPUT_SEL, v & MASK_INPUT_SEL);
      @(negedge clk_sys);
      check({4'h0, positive_input_select, negative_input_select}, {4'h0, v[4:3], v[1:0]});
      $display("field test done");
      wr(ADDR_INPUT_SEL, 8'h00);
      wr(ADDR_IRQ_ENABLE, 8'h01);
      wr(ADDR_CONTROL, 8'h41);
      @(negedge clk_sys);
      check({7'h0, output_valid}, 8'h00);
      for (int i = 0; i < 300 && output_valid !== 1'b1; i++) @(posedge clk_sys);
      foreach (modes[i]) begin
         wr(ADDR_CONTROL, 8'h41 | {2'h0, modes[i], 4'h0});
         level <= 1;
         repeat (6) @(posedge clk_sys);
         @(negedge clk_sys);
         check({7'h0, irq}, {7'h0, modes[i] != EDGE_FALL});
         check({6'h0, event_out, pad_out}, 8'h03);
         rd(ADDR_IRQ_STATUS, {7'h08, modes[i] != EDGE_FALL});
         wr(ADDR_IRQ_STATUS, 8'h01);
         level <= 0;
         @(negedge clk_sys);
         check({7'h0, irq}, 8'h00);
         repeat (6) @(posedge clk_sys);
         rd(ADDR_IRQ_STATUS, {7'h00, modes[i] != EDGE_RISE});
         wr(ADDR_IRQ_STATUS, 8'h01);
      end
      wr(ADDR_INPUT_SEL, 8'h80);
      repeat (6) @(posedge clk_sys);
      rd(ADDR_IRQ_STATUS, 8'h11);
      @(negedge clk_sys);
      check({6'h0, event_out, pad_out}, 8'h03);
      $display("edge test done");
      for (int s = 0; s < 4; s++) begin
         @(posedge clk_sys);
         sleep_mode <= s[1:0];
         @(negedge clk_sys);
         check({7'h0, core_enable}, {7'h0, s < 2});
         check({7'h0, pad_oe_n}, {7'h0, s == 3});
      end
      wr(ADDR_CONTROL, 8'hF1);
      @(posedge clk_sys);
      sleep_mode <= SLEEP_STANDBY;
      @(negedge clk_sys);
      check({7'h0, core_enable}, 8'h01);
      level <= 1;
      repeat (6) @(posedge clk_sys);
      rd(ADDR_IRQ_STATUS, 8'h11);
      clk_requested <= 1;
      repeat (6) @(posedge clk_sys);
      rd(ADDR_IRQ_STATUS, 8'h01);
      $display("sleep test done");
      report_and_stop;
   end
endmodule // tb_comparator_control
`default_nettype wire
